// *** src/gpiop_pkg.sv ***
// constants, register offsets and reset values for the gpio port block
package gpiop_pkg;
    localparam int          DW           = 32;
    localparam int          AW           = 12;
    localparam logic [11:0] OFF_DATA     = 12'h3FC;
    localparam logic [11:0] OFF_DIR      = 12'h400;
    localparam logic [11:0] OFF_IS       = 12'h404;
    localparam logic [11:0] OFF_IBE      = 12'h408;
    localparam logic [11:0] OFF_IEV      = 12'h40C;
    localparam logic [11:0] OFF_IM       = 12'h410;
    localparam logic [11:0] OFF_RIS      = 12'h414;
    localparam logic [11:0] OFF_MIS      = 12'h418;
    localparam logic [11:0] OFF_ICR      = 12'h41C;
    localparam logic [11:0] OFF_AFSEL    = 12'h420;
    localparam logic [11:0] OFF_DRLO     = 12'h500;
    localparam logic [11:0] OFF_DRMID    = 12'h504;
    localparam logic [11:0] OFF_DRHI     = 12'h508;
    localparam logic [11:0] OFF_ODR      = 12'h50C;
    localparam logic [11:0] OFF_PUR      = 12'h510;
    localparam logic [11:0] OFF_PDR      = 12'h514;
    localparam logic [11:0] OFF_SLR      = 12'h518;
    localparam logic [11:0] OFF_DEN      = 12'h51C;
    localparam logic [11:0] OFF_LOCK     = 12'h520;
    localparam logic [11:0] OFF_CR       = 12'h524;
    localparam logic [11:0] OFF_ID_BASE  = 12'hFD0;
    localparam logic [31:0] UNLOCK_KEY   = 32'hC3D2E1F0; // arbitrary key
    localparam logic [7:0]  RST_DRLO     = 8'hFF;
    localparam logic [7:0]  RST_ZERO     = 8'h00;
    // wishbone handshake states, idle and ack
    typedef enum logic [1:0] {
        GPIOP_IDLE = 2'b00,
        GPIOP_ACK  = 2'b01
    } gpiop_bus_e;
endpackage

// *** src/gpiop_pin_sync.sv ***
// two-flop synchroniser with edge/level interrupt detector for each pin
`timescale 1ns/100ps
module gpiop_pin_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // pins and config
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] sense,
    input  wire logic [W-1:0] both,
    input  wire logic [W-1:0] event_pol,
    // results
    output logic      [W-1:0] sync_val,
    output logic      [W-1:0] trig
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;
    wire  [W-1:0] rise = sync_reg & ~prev_reg;
    wire  [W-1:0] fall = ~sync_reg & prev_reg;
    wire  [W-1:0] lvl  = ~(sync_reg ^ event_pol);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_det
            // edge from consecutive samples, level from current sample
            assign trig[i] = sense[i] ? lvl[i] :
                             both[i]  ? (rise[i] | fall[i]) :
                             (event_pol[i] ? rise[i] : fall[i]);
        end
    endgenerate
    assign sync_val = sync_reg;
endmodule

// *** src/gpiop_port.sv ***
// one gpio port: pads, mode, commit lock, interrupts, wishbone slave
//
// Function
// - seven interrupt control registers: sense, both, event, mask, raw, masked, clear
// - all pin requests combine onto one port interrupt line
// - edge interrupt stays pending until software clears it
// - sense 0 edge/1 level; both 0 single/1 both; event 0 low/1 high
// - mask bit 1 passes pin interrupt, 0 blocks it
// - raw status shows condition regardless of mask
// - masked status shows raw and mask, as forwarded
// - writing 1 to clear register clears pending bit, 0 ignored
// - unmasked trigger pin event also pulses converter trigger
// - reprogramming sense/both/event with mask set may cause spurious interrupt
// - alternate select 1 gives pin to peripheral, 0 to gpio data
// - protected alternate bits written only when unlocked and committed
// - only the debug pins are commit protected
// - non-debug pins reset undriven with select, enable, pulls cleared
// - per-pin drive, open drain, pulls, slew and digital enable
// - identification registers are fixed from reset
// - direction 0 input captured, 1 output driven from data
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
module gpiop_port #(
    parameter int          W          = 8,
    parameter logic [7:0]  DEBUG_MASK = 8'h00,
    parameter logic [7:0]  TRIG_MASK  = 8'h00,
    // identification values are arbitrary
    parameter logic [7:0]  ID_PERIPH0 = 8'h5A,
    parameter logic [7:0]  ID_CELL0   = 8'hA5
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [11:0]       wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // pads
    input  wire logic [W-1:0]      pad_in,
    output logic      [W-1:0]      pad_out,
    output logic      [W-1:0]      pad_oe,
    output logic      [W-1:0]      pad_pull_up,
    output logic      [W-1:0]      pad_pull_down,
    output logic      [W-1:0]      pad_drive_low,
    output logic      [W-1:0]      pad_drive_mid,
    output logic      [W-1:0]      pad_drive_high,
    output logic      [W-1:0]      pad_slew,
    output logic      [W-1:0]      pad_input_en,
    // peripheral side
    input  wire logic [W-1:0]      periph_out,
    input  wire logic [W-1:0]      periph_oe,
    output logic      [W-1:0]      periph_in,
    // interrupt and converter trigger
    output logic                   port_irq,
    output logic                   converter_trigger
);
    if (W < 1 || W > 8) begin : g_bad_width
        $error("width must be 1..8");
    end

    localparam logic [W-1:0] DBG = DEBUG_MASK[W-1:0];

    logic [W-1:0] pin_value_reg,         pin_value_next;
    logic [W-1:0] pin_direction_reg;
    logic [W-1:0] irq_sense_select_reg;
    logic [W-1:0] irq_both_edges_select_reg;
    logic [W-1:0] irq_event_polarity_reg;
    logic [W-1:0] irq_mask_reg;
    logic [W-1:0] irq_raw_status_reg,    irq_raw_status_next;
    logic [W-1:0] alt_function_select_reg, alt_function_select_next;
    logic [W-1:0] drive_low_select_reg;
    logic [W-1:0] drive_mid_select_reg;
    logic [W-1:0] drive_high_select_reg;
    logic [W-1:0] open_drain_select_reg;
    logic [W-1:0] pull_up_select_reg;
    logic [W-1:0] pull_down_select_reg;
    logic [W-1:0] slew_control_select_reg;
    logic [W-1:0] digital_input_enable_reg;
    logic [W-1:0] commit_enable_reg;
    logic         commit_lock_reg;
    logic         trig_reg;
    logic [31:0]  rdata_reg;
    logic         ack_reg;
    logic [W-1:0] sync_val;
    logic [W-1:0] trig;

    gpiop_pin_sync #(.W(W)) u_sync (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .pin_in    (pad_in),
        .sense     (irq_sense_select_reg),
        .both      (irq_both_edges_select_reg),
        .event_pol (irq_event_polarity_reg),
        .sync_val  (sync_val),
        .trig      (trig)
    );

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    // bus decode; ack one cycle after request, dropped next cycle
    wire          req    = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire          wr     = req & wb_we_i & wb_sel_i[0];
    wire [W-1:0]  wd     = wb_dat_i[W-1:0];
    wire          data_a = (wb_adr_i[11:10] == 2'b00);
    wire [W-1:0]  amask  = wb_adr_i[W+1:2];
    wire          w_data = wr & data_a;
    wire          w_dir  = wr & hit(wb_adr_i, gpiop_pkg::OFF_DIR);
    wire          w_is   = wr & hit(wb_adr_i, gpiop_pkg::OFF_IS);
    wire          w_ibe  = wr & hit(wb_adr_i, gpiop_pkg::OFF_IBE);
    wire          w_iev  = wr & hit(wb_adr_i, gpiop_pkg::OFF_IEV);
    wire          w_im   = wr & hit(wb_adr_i, gpiop_pkg::OFF_IM);
    wire          w_icr  = wr & hit(wb_adr_i, gpiop_pkg::OFF_ICR);
    wire          w_afs  = wr & hit(wb_adr_i, gpiop_pkg::OFF_AFSEL);
    wire          w_drl  = wr & hit(wb_adr_i, gpiop_pkg::OFF_DRLO);
    wire          w_drm  = wr & hit(wb_adr_i, gpiop_pkg::OFF_DRMID);
    wire          w_drh  = wr & hit(wb_adr_i, gpiop_pkg::OFF_DRHI);
    wire          w_odr  = wr & hit(wb_adr_i, gpiop_pkg::OFF_ODR);
    wire          w_pur  = wr & hit(wb_adr_i, gpiop_pkg::OFF_PUR);
    wire          w_pdr  = wr & hit(wb_adr_i, gpiop_pkg::OFF_PDR);
    wire          w_slr  = wr & hit(wb_adr_i, gpiop_pkg::OFF_SLR);
    wire          w_den  = wr & hit(wb_adr_i, gpiop_pkg::OFF_DEN);
    wire          w_lock = req & wb_we_i & (wb_sel_i == 4'hF)
                         & hit(wb_adr_i, gpiop_pkg::OFF_LOCK);
    wire          w_cr   = wr & hit(wb_adr_i, gpiop_pkg::OFF_CR);

    // data reads reflect pins for inputs, stored value for outputs
    wire [W-1:0]  data_view = (pin_direction_reg & pin_value_reg)
                            | (~pin_direction_reg & sync_val);
    assign pin_value_next = w_data
                          ? (pin_value_reg & ~amask) | (wd & amask)
                          : (pin_value_reg & pin_direction_reg)
                          | (sync_val & ~pin_direction_reg);

    // non-debug bits always change; debug bits only when committed and unlocked
    wire [W-1:0]  afs_open = ~DBG | (commit_enable_reg
                           & {W{~commit_lock_reg}});
    assign alt_function_select_next = (alt_function_select_reg & ~afs_open)
                                    | (wd & afs_open);

    // set beats clear so no event is lost; level bits track the pin
    wire [W-1:0]  clr_bits = w_icr ? wd : '0;
    wire [W-1:0]  held_bits = (irq_raw_status_reg & ~clr_bits)
                            & ~irq_sense_select_reg;
    assign irq_raw_status_next = held_bits | trig;
    wire [W-1:0]  masked = irq_raw_status_reg & irq_mask_reg;
    wire          trig_evt = |(trig & irq_mask_reg
                           & TRIG_MASK[W-1:0]);

    // read mux
    logic [31:0]  rd_mux;
    wire  [11:0]  id_off = wb_adr_i - gpiop_pkg::OFF_ID_BASE;
    always_comb begin
        rd_mux = 32'h00000000;
        if (data_a)
            rd_mux[W-1:0] = data_view & amask;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_DIR))
            rd_mux[W-1:0] = pin_direction_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_IS))
            rd_mux[W-1:0] = irq_sense_select_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_IBE))
            rd_mux[W-1:0] = irq_both_edges_select_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_IEV))
            rd_mux[W-1:0] = irq_event_polarity_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_IM))
            rd_mux[W-1:0] = irq_mask_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_RIS))
            rd_mux[W-1:0] = irq_raw_status_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_MIS))
            rd_mux[W-1:0] = masked;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_AFSEL))
            rd_mux[W-1:0] = alt_function_select_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_DRLO))
            rd_mux[W-1:0] = drive_low_select_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_DRMID))
            rd_mux[W-1:0] = drive_mid_select_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_DRHI))
            rd_mux[W-1:0] = drive_high_select_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_ODR))
            rd_mux[W-1:0] = open_drain_select_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_PUR))
            rd_mux[W-1:0] = pull_up_select_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_PDR))
            rd_mux[W-1:0] = pull_down_select_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_SLR))
            rd_mux[W-1:0] = slew_control_select_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_DEN))
            rd_mux[W-1:0] = digital_input_enable_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_LOCK))
            rd_mux[0] = commit_lock_reg;
        else if (hit(wb_adr_i, gpiop_pkg::OFF_CR))
            rd_mux[W-1:0] = commit_enable_reg;
        else if (id_off == 12'h010)
            rd_mux[7:0] = ID_PERIPH0;
        else if (id_off == 12'h020)
            rd_mux[7:0] = ID_CELL0;
    end

    // bus handshake and data
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg   <= req;
            if (req)
                rdata_reg <= rd_mux;
        end
    end

    // interrupt configuration and status
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            irq_sense_select_reg      <= '0;
            irq_both_edges_select_reg <= '0;
            irq_event_polarity_reg    <= '0;
            irq_mask_reg              <= '0;
            irq_raw_status_reg        <= '0;
            trig_reg                  <= 1'b0;
        end else begin
            if (w_is)  irq_sense_select_reg      <= wd;
            if (w_ibe) irq_both_edges_select_reg <= wd;
            if (w_iev) irq_event_polarity_reg    <= wd;
            if (w_im)  irq_mask_reg              <= wd;
            irq_raw_status_reg <= irq_raw_status_next;
            trig_reg           <= trig_evt;
        end
    end

    // data, mode and pad configuration
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pin_value_reg            <= '0;
            pin_direction_reg        <= '0;
            alt_function_select_reg  <= DBG;
            digital_input_enable_reg <= DBG;
            pull_up_select_reg       <= DBG;
            pull_down_select_reg     <= '0;
            drive_low_select_reg     <= gpiop_pkg::RST_DRLO[W-1:0];
            drive_mid_select_reg     <= '0;
            drive_high_select_reg    <= '0;
            open_drain_select_reg    <= '0;
            slew_control_select_reg  <= '0;
            commit_enable_reg        <= ~DBG;
            commit_lock_reg          <= 1'b1;
        end else begin
            pin_value_reg <= pin_value_next;
            if (w_dir) pin_direction_reg        <= wd;
            if (w_afs) alt_function_select_reg  <= alt_function_select_next;
            if (w_den) digital_input_enable_reg <= wd;
            if (w_pur) pull_up_select_reg       <= wd;
            if (w_pdr) pull_down_select_reg     <= wd;
            if (w_drl) drive_low_select_reg     <= wd;
            if (w_drm) drive_mid_select_reg     <= wd;
            if (w_drh) drive_high_select_reg    <= wd;
            if (w_odr) open_drain_select_reg    <= wd;
            if (w_slr) slew_control_select_reg  <= wd;
            // commit bits writable only for debug pins while unlocked
            if (w_cr && !commit_lock_reg)
                commit_enable_reg <= (commit_enable_reg & ~DBG)
                                   | (wd & DBG);
            if (w_lock)
                commit_lock_reg <= (wb_dat_i != gpiop_pkg::UNLOCK_KEY);
        end
    end

    // pad muxing; open drain only ever drives low
    wire [W-1:0] drv_val = (alt_function_select_reg & periph_out)
                         | (~alt_function_select_reg & pin_value_reg);
    wire [W-1:0] drv_en  = (alt_function_select_reg & periph_oe)
                         | (~alt_function_select_reg
                         & pin_direction_reg);
    assign pad_out        = drv_val & ~open_drain_select_reg;
    assign pad_oe         = drv_en & digital_input_enable_reg
                          & ~(open_drain_select_reg & drv_val);
    assign pad_pull_up    = pull_up_select_reg;
    assign pad_pull_down  = pull_down_select_reg;
    assign pad_drive_low  = drive_low_select_reg;
    assign pad_drive_mid  = drive_mid_select_reg;
    assign pad_drive_high = drive_high_select_reg;
    assign pad_slew       = slew_control_select_reg;
    assign pad_input_en   = digital_input_enable_reg;
    assign periph_in      = sync_val & alt_function_select_reg;
    assign port_irq       = |masked;
    assign converter_trigger = trig_reg;
    assign wb_ack_o       = ack_reg;
    assign wb_dat_o       = rdata_reg;
endmodule

// *** bench/gpiop_port_assertions.sv ***
// assertion checker for the gpio port bus, pads and interrupt
`timescale 1ns/100ps
module gpiop_port_chk #(
    parameter int         W          = 8,
    parameter logic [7:0] DEBUG_MASK = 8'h00,
    parameter logic [7:0] ID_PERIPH0 = 8'h5A
) (
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         rstn,
    // bus
    input wire logic         wb_cyc_i,
    input wire logic         wb_stb_i,
    input wire logic         wb_we_i,
    input wire logic [11:0]  wb_adr_i,
    input wire logic [3:0]   wb_sel_i,
    input wire logic [31:0]  wb_dat_i,
    input wire logic [31:0]  wb_dat_o,
    input wire logic         wb_ack_o,
    // pads and interrupt
    input wire logic [W-1:0] pad_oe,
    input wire logic [W-1:0] pad_pull_up,
    input wire logic [W-1:0] pad_drive_low,
    input wire logic         port_irq,
    input wire logic         converter_trigger
);
    logic rd_ack;
    assign rd_ack = wb_ack_o && !wb_we_i;
    default clocking @(posedge sys_clk);
    endclocking
    AST_ACK_NEXT: assert property (disable iff (!rstn)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    AST_ACK_PULSE: assert property (disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_RST_QUIET: assert property (!rstn |=> !wb_ack_o && !port_irq &&
        !converter_trigger && (pad_oe & ~DEBUG_MASK[W-1:0]) == '0)
        else $error("outputs active after reset");
    AST_RST_PADS: assert property (!rstn |=> pad_drive_low == '1 &&
        pad_pull_up == DEBUG_MASK[W-1:0])
        else $error("pad settings wrong after reset");
    AST_PUR_WRITE: assert property (disable iff (!rstn)
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 12'h510
        |=> pad_pull_up == $past(wb_dat_i[W-1:0]))
        else $error("pull-up pads do not follow write");
    AST_TRIG_IRQ: assert property (disable iff (!rstn)
        converter_trigger |-> port_irq)
        else $error("trigger without port interrupt");
    AST_ID_READ: assert property (disable iff (!rstn)
        rd_ack && wb_adr_i == 12'hFE0 |-> wb_dat_o == {24'h0, ID_PERIPH0})
        else $error("identification value wrong");
    AST_UPPER_ZERO: assert property (disable iff (!rstn)
        rd_ack |-> wb_dat_o[31:W] == '0)
        else $error("upper read bits not zero");
    AST_UNMAPPED: assert property (disable iff (!rstn)
        rd_ack && wb_adr_i == 12'h600 |-> wb_dat_o == '0)
        else $error("unmapped read not zero");
    COV_IRQ: cover property (disable iff (!rstn) $rose(port_irq));
    COV_TRIG: cover property (disable iff (!rstn) converter_trigger);
    COV_ID: cover property (disable iff (!rstn)
        rd_ack && wb_adr_i == 12'hFE0);
endmodule

bind gpiop_port gpiop_port_chk #(
    .W(W), .DEBUG_MASK(DEBUG_MASK), .ID_PERIPH0(ID_PERIPH0)
) u_chk (
    .sys_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pad_oe,
    .pad_pull_up, .pad_drive_low, .port_irq, .converter_trigger
);

// *** bench/gpiop_pin_model.sv ***
// far side model: pin sources and a peripheral drive pattern
`timescale 1ns/100ps
module gpiop_pin_model #(
    parameter int W = 8
) (
    // clock
    input  wire logic         sys_clk,
    // level the outside world puts on each pin
    input  wire logic [W-1:0] ext_level,
    // port pads
    input  wire logic [W-1:0] pad_out,
    input  wire logic [W-1:0] pad_oe,
    output logic      [W-1:0] pad_in,
    // peripheral drive
    output logic      [W-1:0] periph_out
);
    logic [W-1:0] pattern_reg = '0;
    // driven pin reads back the port, else the held source level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
    // moves every cycle so a stale peripheral value cannot match
    always @(posedge sys_clk) begin
        pattern_reg <= pattern_reg + W'(8'h5B);
    end
    assign periph_out = pattern_reg;
endmodule

// *** bench/tb_gpiop_port.sv ***
// self-checking bench for one gpio port with debug and trigger pins
`timescale 1ns/100ps
module tb_gpiop_port;
    localparam logic [7:0] IDP = 8'h3C; // arbitrary value
    localparam logic [7:0] IDC = 8'hC3; // arbitrary value
    logic        sys_clk   = 1'b0;
    logic        rstn      = 1'b0;
    logic        wb_cyc_i  = 1'b0;
    logic        wb_stb_i  = 1'b0;
    logic        wb_we_i   = 1'b0;
    logic [11:0] wb_adr_i  = '0;
    logic [3:0]  wb_sel_i  = 4'hF;
    logic [31:0] wb_dat_i  = '0;
    logic [7:0]  periph_oe = '0;
    logic [7:0]  ext_level = '0;
    logic [31:0] wb_dat_o, rd, v, cnt;
    logic        wb_ack_o, port_irq, converter_trigger;
    logic [7:0]  pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
    logic [7:0]  pad_drive_low, pad_drive_mid, pad_drive_high;
    logic [7:0]  pad_slew, pad_input_en, periph_out, periph_in;
    logic [2:0]  c;
    logic [7:0]  pv [7];
    int          bad_count       = 0;
    int          samples_checked = 0;
    int          seed            = 32'hb94432bd;
    logic [11:0] ra [9] = '{12'h510, 12'h51C, 12'h420, 12'h514, 12'h500,
                            12'h520, 12'h524, 12'hFE0, 12'hFF0};
    logic [31:0] rv [9] = '{32'h80, 32'h80, 32'h80, 32'h0, 32'hFF,
                            32'h1, 32'h7F, {24'h0, IDP}, {24'h0, IDC}};
    logic [11:0] pr [7] = '{12'h504, 12'h508, 12'h50C, 12'h510,
                            12'h514, 12'h518, 12'h408};
    logic [2:0]  modes [5] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b101};

    always #2.5 sys_clk = ~sys_clk;

    gpiop_port #(.W(8), .DEBUG_MASK(8'h80), .TRIG_MASK(8'h10),
        .ID_PERIPH0(IDP), .ID_CELL0(IDC)) dut (
        .sys_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pad_in, .pad_out,
        .pad_oe, .pad_pull_up, .pad_pull_down, .pad_drive_low,
        .pad_drive_mid, .pad_drive_high, .pad_slew, .pad_input_en,
        .periph_out, .periph_oe, .periph_in, .port_irq,
        .converter_trigger);
    gpiop_pin_model #(.W(8)) u_pins (
        .sys_clk, .ext_level, .pad_out, .pad_oe, .pad_in, .periph_out);

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i}
            <= {2'b11, w, 4'hF, a, d};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (wb_ack_o !== 1'b1) begin
            bad_count++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdchk(input string what, input logic [11:0] a,
                         input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        check(what, rd, exp);
    endtask
    // sync plus detect takes three edges; one spare
    task automatic hold_pins();
        repeat (4) @(posedge sys_clk);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (ra[i]) rdchk("reset value", ra[i], rv[i]);
        rdchk("unmapped", 12'h600, 32'h0);
        foreach (pr[i]) begin
            v = $random(seed);
            pv[i] = v[7:0];
            wr(pr[i], v);
            rdchk("pad setting", pr[i], {24'h0, v[7:0]});
        end
        check("pad outs", {pad_drive_mid, pad_drive_high, pad_pull_down,
              pad_slew}, {pv[0], pv[1], pv[4], pv[5]});
        wr(12'h50C, 32'h0);
        wr(12'h408, 32'h0);
        // debug pin 7 must survive a locked write
        wr(12'h420, 32'h7F);
        rdchk("alt locked", 12'h420, 32'hFF);
        wr(12'h524, 32'hFF);
        rdchk("commit locked", 12'h524, 32'h7F);
        wr(12'h520, gpiop_pkg::UNLOCK_KEY);
        rdchk("lock open", 12'h520, 32'h0);
        wr(12'h524, 32'hFF);
        rdchk("commit open", 12'h524, 32'hFF);
        wr(12'h420, 32'h0);
        rdchk("alt committed", 12'h420, 32'h0);
        wr(12'h520, 32'h0);
        rdchk("lock closed", 12'h520, 32'h1);
        // output drivers need the digital enable on every pin
        wr(12'h51C, 32'hFF);
        check("input enable", pad_input_en, 32'hFF);
        wr(12'h400, 32'hFF);
        v = $random(seed);
        wr(12'h3FC, v);
        @(negedge sys_clk);
        check("gpio drive", {pad_oe, pad_out}, {8'hFF, v[7:0]});
        check("periph idle", periph_in, 32'h0);
        wr(12'h400, 32'h0);
        ext_level <= 8'($random(seed));
        periph_oe <= 8'($random(seed));
        hold_pins();
        rdchk("pin capture", 12'h3FC, {24'h0, ext_level});
        wr(12'h420, 32'hFF);
        @(negedge sys_clk);
        check("alt drive", {pad_oe & 8'h7F, pad_out & 8'h7F},
              {periph_oe & 8'h7F, periph_out & 8'h7F});
        // driven pins read back the peripheral, so release them first
        @(posedge sys_clk) periph_oe <= 8'h00;
        hold_pins();
        check("alt sample", periph_in & 8'h7F, ext_level & 8'h7F);
        wr(12'h420, 32'h0);
        // pin 2 through every sense/both/event combination in use
        foreach (modes[m]) begin
            c = modes[m];
            wr(12'h410, 32'h0);
            wr(12'h404, {29'h0, c[2], 2'b00});
            wr(12'h408, {29'h0, c[1], 2'b00});
            wr(12'h40C, {29'h0, c[0], 2'b00});
            ext_level[2] <= ~c[0];
            hold_pins();
            wr(12'h41C, 32'hFF);
            wr(12'h410, 32'h04);
            rdchk("raw idle", 12'h414, 32'h0);
            ext_level[2] <= c[0];
            hold_pins();
            rdchk("raw", 12'h414, 32'h04);
            rdchk("masked", 12'h418, 32'h04);
            check("irq", port_irq, 32'h1);
            wr(12'h410, 32'h0);
            rdchk("masked off", 12'h418, 32'h0);
            check("irq off", port_irq, 32'h0);
            rdchk("raw unmasked", 12'h414, 32'h04);
            wr(12'h410, 32'h04);
            wr(12'h41C, 32'hFB);
            rdchk("clear zero", 12'h414, 32'h04);
            wr(12'h41C, 32'h04);
            rdchk("clear one", 12'h414, {29'h0, c[2], 2'b00});
            ext_level[2] <= ~c[0];
            hold_pins();
            rdchk("released", 12'h414, {29'h0, c[1] & ~c[2], 2'b00});
        end
        // trigger pin rising edge, masked then unmasked
        wr(12'h404, 32'h0);
        wr(12'h40C, 32'h10);
        for (int k = 0; k < 2; k++) begin
            wr(12'h410, k ? 32'h10 : 32'h0);
            ext_level[4] <= 1'b0;
            hold_pins();
            wr(12'h41C, 32'hFF);
            ext_level[4] <= 1'b1;
            cnt = '0;
            repeat (8) @(posedge sys_clk) cnt += converter_trigger;
            check("trigger pulses", cnt, k);
        end
        finish_test();
    end
endmodule
